// ===== design/ccid_cfg.svh
// timing, angle and count constants for the crank and cam decoder
`ifndef CCID_CFG_SVH
`define CCID_CFG_SVH

// ==========================================================
// clock and speed bounds
`define CCID_CLK_HZ 125000000
`define CCID_RPM_LO 30
`define CCID_RPM_HI 9000
`define CCID_RPM_EN 200

// ==========================================================
// per-position cycle counts: 60 positions per rev, so clk*60/(rpm*60)
`define CCID_LO_CYC (`CCID_CLK_HZ / `CCID_RPM_LO)
`define CCID_HI_CYC ((`CCID_CLK_HZ + `CCID_RPM_HI - 1) / `CCID_RPM_HI)
`define CCID_EN_CYC (`CCID_CLK_HZ / `CCID_RPM_EN)
`define CCID_CNT_W 24

// ==========================================================
// wheel geometry and angles
`define CCID_TOOTH_POS 60
`define CCID_TOOTH_REAL 58
`define CCID_LAST_TOOTH (`CCID_TOOTH_REAL - 1)
`define CCID_GAP_SPAN (`CCID_TOOTH_POS - `CCID_TOOTH_REAL + 1)
`define CCID_DEG_TOOTH 6
`define CCID_DEG_REV 360
`define CCID_DEG_CYCLE 720
`define CCID_BEFORE_TOP_DEAD_CENTRE_DEG 10
`define CCID_TDC1_DEG 60
`define CCID_VCT_TEETH 5
`define CCID_COIL_N 4

`endif

// ===== design/ccid_crank_cam_decoder.sv
// crank and cam decoder: sync, profile pulse, coils and fault flags
`timescale 1ns/1ps
`include "ccid_cfg.svh"

module ccid_crank_cam_decoder #(
   parameter ccid_pkg::ccid_cnt_t LO_CYC = ccid_pkg::ccid_cnt_t'(`CCID_LO_CYC),
   parameter ccid_pkg::ccid_cnt_t HI_CYC = ccid_pkg::ccid_cnt_t'(`CCID_HI_CYC),
   parameter ccid_pkg::ccid_cnt_t EN_CYC = ccid_pkg::ccid_cnt_t'(`CCID_EN_CYC)
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic crank_position_input,
   input wire logic [1:0] cam_position_input,
   input wire logic vct_fitted,
   input wire logic etc_fitted,
   input wire ccid_pkg::ccid_cyl_t cyl_sel,
   input wire logic fault_clear,
   output logic fuel_enable,
   output logic [`CCID_COIL_N-1:0] coil_drive,
   output logic profile_pulse_out,
   output logic synced,
   output logic crank_fault,
   output logic cam_fault,
   output logic [1:0] cam_intermittent,
   output logic variable_cam_timing_enable,
   output logic electronic_throttle_control_fault
);
   import ccid_pkg::*;

   localparam logic [5:0] LAST_TOOTH = 6'(`CCID_LAST_TOOTH);
   localparam logic [4:0] SUB_NORM = 5'(`CCID_DEG_TOOTH - 1);
   localparam logic [4:0] SUB_GAP = 5'(`CCID_GAP_SPAN * `CCID_DEG_TOOTH - 1);
   localparam logic [9:0] DEG_REV = 10'(`CCID_DEG_REV);
   localparam logic [9:0] DEG_CYC = 10'(`CCID_DEG_CYCLE);
   localparam logic [9:0] DEG_TOOTH = 10'(`CCID_DEG_TOOTH);
   localparam logic [9:0] ANCHOR = 10'((`CCID_TDC1_DEG + `CCID_DEG_CYCLE
      - `CCID_BEFORE_TOP_DEAD_CENTRE_DEG) % `CCID_DEG_CYCLE);
   localparam logic [2:0] VCT_N = 3'(`CCID_VCT_TEETH);

   ccid_tooth_if tif();

   // pin synchroniser stages: bit 0 crank, bits 2:1 cam banks
   logic [2:0] pin_s0_q;
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_lvl_q;
   logic [2:0] pin_lvl_d;
   logic [2:0] rise;

   ccid_state_t state_q;
   logic [5:0] tooth_cnt_q;
   logic [4:0] sub_q;
   logic [9:0] angle_q;
   logic half_q;
   logic half_d;
   logic cam_par_q;
   logic [3:0] pip_cnt_q;
   logic cam_armed_q;
   logic [2:0] vct_cnt_q [2];
   logic vct_armed_q;
   logic profile_q;
   logic [`CCID_COIL_N-1:0] coil_q;
   logic fuel_q;
   logic crank_fault_q;
   logic cam_fault_q;
   logic [1:0] cam_int_q;
   logic etc_fault_q;

   logic seq_on;
   logic wrong_gap;
   logic no_gap;
   logic sync_err;
   logic crank_evt;
   logic good_gap;
   logic run_ok;
   logic new_cycle;
   logic [4:0] sub_lim;
   logic [9:0] off;
   logic [7:0] per;
   logic [9:0] phase;
   logic [9:0] slot;
   logic pip_high;
   logic pip_rise;
   logic cam_en;
   logic vct_en;
   logic cam_set;
   logic [1:0] int_set;

   ccid_tooth_timer #(
      .LO_CYC(LO_CYC),
      .HI_CYC(HI_CYC),
      .EN_CYC(EN_CYC)
   ) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .tif(tif.timer)
   );

   // ==========================================================
   // pin inputs: three stages, a change counts when stages 2 and 3 agree
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_s0_q <= '0;
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_lvl_q <= '0;
      end else begin
         pin_s0_q <= {cam_position_input, crank_position_input};
         pin_s1_q <= pin_s0_q;
         pin_s2_q <= pin_s1_q;
         pin_lvl_q <= pin_lvl_d;
      end
   end

   // accepted level and its rising edge
   assign pin_lvl_d = (~(pin_s1_q ^ pin_s2_q) & pin_s2_q)
      | ((pin_s1_q ^ pin_s2_q) & pin_lvl_q);
   assign rise = pin_lvl_d & ~pin_lvl_q;
   assign tif.tooth_edge = rise[0];

   // ==========================================================
   // crank sequence checks
   assign seq_on = (state_q != ST_HUNT);
   assign wrong_gap = rise[0] && tif.gap && seq_on
      && (tooth_cnt_q != LAST_TOOTH);
   assign no_gap = rise[0] && !tif.gap && seq_on
      && (tooth_cnt_q == LAST_TOOTH);
   assign sync_err = wrong_gap || no_gap || tif.too_fast
      || tif.too_slow;
   assign crank_evt = sync_err && tif.speed_ok;
   assign good_gap = rise[0] && tif.gap && !sync_err;
   assign run_ok = (state_q == ST_RUN) && !sync_err;
   assign new_cycle = good_gap && half_q && (state_q == ST_RUN);

   // synchronisation state: hunt, confirm gap, confirm cylinder one, run
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_HUNT;
      end else if (sync_err) begin
         state_q <= ST_HUNT;
      end else if (good_gap) begin
         unique case (state_q)
            ST_HUNT: state_q <= ST_GAP;
            ST_GAP: state_q <= ST_CAM;
            ST_CAM: state_q <= ST_RUN;
            ST_RUN: state_q <= ST_RUN;
         endcase
      end
   end

   // tooth counter, zeroed by the gap
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tooth_cnt_q <= '0;
      end else if (rise[0] && tif.gap) begin
         tooth_cnt_q <= '0;
      end else if (rise[0] && (tooth_cnt_q != '1)) begin
         tooth_cnt_q <= tooth_cnt_q + 6'h01;
      end
   end

   // cam parity per revolution picks the revolution of cylinder one
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cam_par_q <= 1'b0;
      end else if (rise[0] && tif.gap) begin
         cam_par_q <= 1'b0;
      end else if (rise[1]) begin
         cam_par_q <= ~cam_par_q;
      end
   end

   // revolution half of the engine cycle
   always_comb begin
      half_d = half_q;
      if (good_gap && (state_q == ST_CAM)) begin
         half_d = ~cam_par_q;
      end else if (good_gap) begin
         half_d = ~half_q;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         half_q <= 1'b0;
      end else begin
         half_q <= half_d;
      end
   end

   // ==========================================================
   // crank angle: snapped at each tooth, interpolated in between
   assign sub_lim = (tooth_cnt_q == LAST_TOOTH) ? SUB_GAP : SUB_NORM;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         angle_q <= '0;
         sub_q <= '0;
      end else if (rise[0]) begin
         sub_q <= '0;
         angle_q <= (half_d ? DEG_REV : 10'h000) + (tif.gap ? 10'h000
            : 10'({4'h0, tooth_cnt_q} + 10'h001) * DEG_TOOTH);
      end else if (tif.deg_tick && (sub_q < sub_lim)) begin
         sub_q <= sub_q + 5'h01;
         angle_q <= angle_q + 10'h001;
      end
   end

   // ==========================================================
   // profile pulse and coil selection
   assign off = (angle_q >= ANCHOR) ? (angle_q - ANCHOR)
      : (angle_q + DEG_CYC - ANCHOR);
   assign per = ccid_period(cyl_sel);
   assign phase = off % {2'b00, per};
   assign slot = off / {2'b00, per};
   assign pip_high = (phase < {3'b000, per[7:1]});
   assign pip_rise = run_ok && pip_high && !profile_q;

   // outputs drop the cycle after a crank fault
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         profile_q <= 1'b0;
         coil_q <= '0;
         fuel_q <= 1'b0;
      end else begin
         profile_q <= run_ok && pip_high;
         coil_q <= (run_ok && pip_high)
            ? (`CCID_COIL_N'(1) << slot[1:0]) : '0;
         fuel_q <= run_ok;
      end
   end

   // ==========================================================
   // cam to profile ratio check, plain cam wheel only
   assign cam_en = run_ok && tif.speed_ok && !vct_fitted;

   always_comb begin
      cam_set = 1'b0;
      if (cam_en && cam_armed_q) begin
         if (rise[1] && (pip_cnt_q != ccid_cyl_n(cyl_sel))) begin
            cam_set = 1'b1;
         end else if (!rise[1] && pip_rise
            && (pip_cnt_q >= ccid_cyl_n(cyl_sel))) begin
            cam_set = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pip_cnt_q <= '0;
         cam_armed_q <= 1'b0;
      end else if (!cam_en) begin
         pip_cnt_q <= '0;
         cam_armed_q <= 1'b0;
      end else if (rise[1]) begin
         pip_cnt_q <= {3'b000, pip_rise};
         cam_armed_q <= 1'b1;
      end else if (pip_rise && (pip_cnt_q != '1)) begin
         pip_cnt_q <= pip_cnt_q + 4'h1;
      end
   end

   // ==========================================================
   // five-tooth cam: edge count per engine cycle for each bank
   assign vct_en = run_ok && tif.speed_ok && vct_fitted;

   always_comb begin
      for (int b = 0; b < 2; b++) begin
         int_set[b] = vct_en && vct_armed_q && new_cycle
            && (vct_cnt_q[b] != VCT_N);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         vct_armed_q <= 1'b0;
         for (int b = 0; b < 2; b++) begin
            vct_cnt_q[b] <= '0;
         end
      end else begin
         if (!vct_en) begin
            vct_armed_q <= 1'b0;
         end else if (new_cycle) begin
            vct_armed_q <= 1'b1;
         end
         for (int b = 0; b < 2; b++) begin
            if (new_cycle) begin
               vct_cnt_q[b] <= {2'b00, rise[b+1]};
            end else if (rise[b+1] && (vct_cnt_q[b] != '1)) begin
               vct_cnt_q[b] <= vct_cnt_q[b] + 3'h1;
            end
         end
      end
   end

   // ==========================================================
   // sticky fault flags: a new event wins over the clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         crank_fault_q <= 1'b0;
         etc_fault_q <= 1'b0;
         cam_fault_q <= 1'b0;
         cam_int_q <= '0;
      end else begin
         crank_fault_q <= crank_evt || (crank_fault_q && !fault_clear);
         etc_fault_q <= (crank_evt && etc_fitted)
            || (etc_fault_q && !fault_clear);
         cam_fault_q <= cam_set || (cam_fault_q && !fault_clear);
         cam_int_q <= int_set | (cam_int_q & ~{2{fault_clear}});
      end
   end

   // ==========================================================
   // outputs
   assign fuel_enable = fuel_q;
   assign coil_drive = coil_q;
   assign profile_pulse_out = profile_q;
   assign synced = (state_q == ST_RUN);
   assign crank_fault = crank_fault_q;
   assign cam_fault = cam_fault_q;
   assign cam_intermittent = cam_int_q;
   assign variable_cam_timing_enable = vct_fitted && (state_q == ST_RUN)
      && (cam_int_q == 2'b00);
   assign electronic_throttle_control_fault = etc_fault_q;
endmodule : ccid_crank_cam_decoder

// ===== design/ccid_pkg.sv
// types and helper functions for the crank and cam decoder
`include "ccid_cfg.svh"

package ccid_pkg;

   // ==========================================================
   // types
   typedef logic [`CCID_CNT_W-1:0] ccid_cnt_t;

   typedef enum logic [1:0] {
      ST_HUNT = 2'b00,
      ST_GAP = 2'b01,
      ST_CAM = 2'b10,
      ST_RUN = 2'b11
   } ccid_state_t;

   typedef enum logic [1:0] {
      CYL_4 = 2'b00,
      CYL_6 = 2'b01,
      CYL_8 = 2'b10,
      CYL_10 = 2'b11
   } ccid_cyl_t;

   // ==========================================================
   // cylinder count for a selection
   function automatic logic [3:0] ccid_cyl_n(input ccid_cyl_t sel);
      unique case (sel)
         CYL_4: return 4'h4;
         CYL_6: return 4'h6;
         CYL_8: return 4'h8;
         CYL_10: return 4'hA;
      endcase
   endfunction : ccid_cyl_n

   // profile period in crank degrees: one cycle split over the cylinders
   function automatic logic [7:0] ccid_period(input ccid_cyl_t sel);
      return 8'(`CCID_DEG_CYCLE / int'(ccid_cyl_n(sel)));
   endfunction : ccid_period

endpackage : ccid_pkg

// ===== design/ccid_tooth_if.sv
// tooth timing signals between the decoder core and its tooth timer
`timescale 1ns/1ps

interface ccid_tooth_if;
   logic tooth_edge;
   logic gap;
   logic too_fast;
   logic too_slow;
   logic speed_ok;
   logic deg_tick;

   modport timer (
      input tooth_edge,
      output gap,
      output too_fast,
      output too_slow,
      output speed_ok,
      output deg_tick
   );

   modport core (
      output tooth_edge,
      input gap,
      input too_fast,
      input too_slow,
      input speed_ok,
      input deg_tick
   );
endinterface : ccid_tooth_if

// ===== design/ccid_tooth_timer.sv
// tooth interval timer: gap, speed bounds and degree interpolation
`timescale 1ns/1ps
`include "ccid_cfg.svh"

module ccid_tooth_timer #(
   parameter ccid_pkg::ccid_cnt_t LO_CYC = '1,
   parameter ccid_pkg::ccid_cnt_t HI_CYC = '1,
   parameter ccid_pkg::ccid_cnt_t EN_CYC = '1
) (
   input wire logic clock,
   input wire logic rst_n,
   ccid_tooth_if.timer tif
);
   import ccid_pkg::*;

   localparam ccid_cnt_t SLOW_LIM = ccid_cnt_t'(`CCID_GAP_SPAN * LO_CYC);
   localparam ccid_cnt_t CNT_MAX = '1;

   ccid_cnt_t cnt_q;
   ccid_cnt_t prev_q;
   ccid_cnt_t step_q;
   ccid_cnt_t deg_cnt_q;
   logic speed_ok_q;
   logic [`CCID_CNT_W:0] gap_lim;
   logic deg_wrap;

   // ==========================================================
   // interval checks: gap against the previous tooth, speed against fixed bounds
   assign gap_lim = {1'b0, prev_q} + {2'b00, prev_q[`CCID_CNT_W-1:1]};
   assign tif.gap = tif.tooth_edge && ({1'b0, cnt_q} > gap_lim);
   assign tif.too_fast = tif.tooth_edge && (cnt_q < HI_CYC);
   assign tif.too_slow = (cnt_q >= SLOW_LIM);
   assign tif.speed_ok = speed_ok_q;
   assign deg_wrap = (deg_cnt_q + ccid_cnt_t'(1)) >= step_q;
   assign tif.deg_tick = deg_wrap && !tif.tooth_edge;

   // free-running interval counter, restarted by each tooth
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         prev_q <= '0;
      end else if (tif.tooth_edge) begin
         cnt_q <= ccid_cnt_t'(1);
         prev_q <= cnt_q;
      end else if (cnt_q != CNT_MAX) begin
         cnt_q <= cnt_q + ccid_cnt_t'(1);
      end
   end

   // speed qualifier and degree step follow normal teeth only
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         speed_ok_q <= 1'b0;
         step_q <= CNT_MAX;
      end else if (tif.tooth_edge && !tif.gap) begin
         speed_ok_q <= (cnt_q <= EN_CYC);
         step_q <= ccid_cnt_t'(cnt_q / `CCID_DEG_TOOTH);
      end
   end

   // one tick per interpolated crank degree
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         deg_cnt_q <= '0;
      end else if (tif.tooth_edge || deg_wrap) begin
         deg_cnt_q <= '0;
      end else begin
         deg_cnt_q <= deg_cnt_q + ccid_cnt_t'(1);
      end
   end
endmodule : ccid_tooth_timer

// ===== sim/ccid_decoder_properties.sv
// port-level assertions for the crank and cam decoder
`timescale 1ns/1ps
`include "ccid_cfg.svh"

module ccid_decoder_properties (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic vct_fitted,
   input wire logic etc_fitted,
   input wire logic fault_clear,
   input wire logic fuel_enable,
   input wire logic [`CCID_COIL_N-1:0] coil_drive,
   input wire logic profile_pulse_out,
   input wire logic synced,
   input wire logic crank_fault,
   input wire logic [1:0] cam_intermittent,
   input wire logic variable_cam_timing_enable,
   input wire logic electronic_throttle_control_fault
);
   // ==========================================================
   // clocking and fault sequences
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence s_fault_set;
      $rose(crank_fault);
   endsequence
   sequence s_output_cut;
      (!fuel_enable && coil_drive == '0) [*8];
   endsequence

   // ==========================================================
   // assertions
   chk_fault_cuts_out: assert property (
      s_fault_set |-> s_output_cut)
      else $error("fuel or coil active after crank fault");
   chk_fault_drops_sync: assert property (
      s_fault_set |-> !synced)
      else $error("still synced after crank fault");
   chk_etc_follows: assert property (
      s_fault_set ##0 etc_fitted |-> electronic_throttle_control_fault)
      else $error("throttle fault missing on crank fault");
   chk_etc_absent: assert property (
      !etc_fitted |-> !electronic_throttle_control_fault)
      else $error("throttle fault without throttle control");
   chk_coil_onehot: assert property (
      $onehot0(coil_drive))
      else $error("more than one coil driven");
   chk_coil_dwell: assert property (
      coil_drive != '0 |-> profile_pulse_out && synced)
      else $error("coil driven outside profile high");
   chk_fuel_sync: assert property (
      !synced |=> !fuel_enable)
      else $error("fuel enabled while unsynced");
   chk_profile_quiet: assert property (
      !synced [*2] |-> !profile_pulse_out)
      else $error("profile pulse while unsynced");
   chk_vct_enable: assert property (
      variable_cam_timing_enable ==
      (vct_fitted && synced && cam_intermittent == 2'h0))
      else $error("cam timing enable wrong");
   chk_crank_sticky: assert property (
      crank_fault && !fault_clear |=> crank_fault)
      else $error("crank fault dropped without clear");
   chk_clear_only: assert property (
      $fell(crank_fault) |-> $past(fault_clear))
      else $error("crank fault fell with no clear");
   chk_cam_sticky: assert property (
      !fault_clear |=> (cam_intermittent & $past(cam_intermittent))
      == $past(cam_intermittent))
      else $error("cam intermittent flag dropped");
endmodule : ccid_decoder_properties

bind ccid_crank_cam_decoder ccid_decoder_properties u_props (
   .clock(clock), .rst_n(rst_n), .vct_fitted(vct_fitted),
   .etc_fitted(etc_fitted), .fault_clear(fault_clear),
   .fuel_enable(fuel_enable), .coil_drive(coil_drive),
   .profile_pulse_out(profile_pulse_out), .synced(synced),
   .crank_fault(crank_fault), .cam_intermittent(cam_intermittent),
   .variable_cam_timing_enable(variable_cam_timing_enable),
   .electronic_throttle_control_fault(electronic_throttle_control_fault)
);

// ===== sim/ccid_sensor_model.sv
// behavioural crank wheel and cam pickups
`timescale 1ns/1ps

module ccid_sensor_model (
   input wire logic clock,
   input wire logic run,
   input wire logic [15:0] period,
   input wire logic fill_gap,
   input wire logic cam_five,
   input wire logic [1:0] cam_drop,
   output logic crank,
   output logic [1:0] cam
);
   int pos;
   logic cam_rev;

   // cam tooth present at this crank position
   function automatic logic cam_at(input int p, input logic drop);
      if (cam_five) begin
         return p % 10 == 5 && p < 50 && !(drop && p == 25);
      end
      return p == 30 && !drop;
   endfunction : cam_at

   // one position per period, last two positions empty; wheel stops
   // at position zero while run is low
   initial begin
      crank = 1'h0;
      cam = 2'h0;
      pos = 0;
      cam_rev = 1'h1;
      forever begin
         @(posedge clock);
         if (!run) begin
            pos = 0;
            cam_rev = 1'h1;
         end else begin
            crank <= pos < 58 || (pos == 58 && fill_gap);
            cam[0] <= cam_rev && cam_at(pos, cam_drop[0]);
            cam[1] <= cam_rev && cam_at(pos, cam_drop[1]);
            repeat (period / 2) @(posedge clock);
            crank <= 1'h0;
            cam <= 2'h0;
            repeat (period - period / 2 - 1) @(posedge clock);
            pos = (pos + 1) % 60;
            cam_rev = cam_rev ^ (pos == 0); // cam once per two revs
         end
      end
   end
endmodule : ccid_sensor_model

// ===== sim/test_ccid_crank_cam_decoder.sv
// self-checking bench for the crank and cam decoder
`timescale 1ns/1ps
`include "ccid_cfg.svh"

module test_ccid_crank_cam_decoder;
   import ccid_pkg::*;
   logic clock, rst_n, run, fill, cam5, variable_cam_timing, electronic_throttle_control, fclr;
   logic [15:0] period;
   logic [1:0] drop, cam, cint;
   ccid_cyl_t cyl;
   logic crank, fuel, prof, sync, cf, camf, vcte, etcf;
   logic [3:0] coil;
   int num_errors, cmp_count;

   // ==========================================================
   // design, wheel and clock
   ccid_crank_cam_decoder #(.LO_CYC(24'h258), .HI_CYC(24'h14),
      .EN_CYC(24'h12C)) DUT (
      .clock(clock), .rst_n(rst_n), .crank_position_input(crank),
      .cam_position_input(cam), .vct_fitted(variable_cam_timing), .etc_fitted(electronic_throttle_control),
      .cyl_sel(cyl), .fault_clear(fclr), .fuel_enable(fuel),
      .coil_drive(coil), .profile_pulse_out(prof), .synced(sync),
      .crank_fault(cf), .cam_fault(camf), .cam_intermittent(cint),
      .variable_cam_timing_enable(vcte),
      .electronic_throttle_control_fault(etcf));
   ccid_sensor_model wheel (.clock(clock), .run(run), .period(period),
      .fill_gap(fill), .cam_five(cam5), .cam_drop(drop), .crank(crank),
      .cam(cam));

   initial begin
      clock = 1'h0;
      forever #4 clock = ~clock;
   end

   // ==========================================================
   // shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask : check

   task automatic end_sim;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   // poll a flag at falling edges: 0 sync, 1 crank, 2 cam, 3 cam loss
   task automatic wait_for(input int sel, input int lim, output int n);
      logic hit;
      n = 0;
      hit = 1'h0;
      while (n < lim && !hit) begin
         @(negedge clock);
         n++;
         hit = sel == 0 ? sync === 1'h1 : sel == 1 ? cf === 1'h1 :
            sel == 2 ? camf === 1'h1 : cint !== 2'h0;
      end
      if (!hit) begin
         num_errors++;
         $display("unexpected at %0t: wait %0d ran out", $time, sel);
         end_sim();
      end
   endtask : wait_for

   // stop the wheel, reset with new straps, start from the gap
   task automatic restart(input ccid_cyl_t c, input logic v,
      input logic e, input logic [15:0] p);
      @(posedge clock);
      run <= 1'h0;
      repeat (30) @(posedge clock);
      cyl <= c;
      {variable_cam_timing, cam5, electronic_throttle_control, period} <= {v, v, e, p};
      {drop, fill, rst_n} <= 4'h0;
      repeat (6) @(posedge clock);
      rst_n <= 1'h1;
      // let the interval counter pass the overspeed bound before the
      // first tooth, else the first gap is missed
      repeat (30) @(posedge clock);
      run <= 1'h1;
   endtask : restart

   // ==========================================================
   // scenarios
   // sync time, profile count and duty over one full cycle
   task automatic t_profile(input ccid_cyl_t c);
      int n, rises, high;
      logic seen, last;
      restart(c, 1'h0, 1'h0, 16'h18);
      wait_for(0, 12000, n);
      check(n > 2800, 1'h1);
      {rises, high, seen} = '0;
      last = 1'h1; // skip a pulse already cut short by sync
      repeat (2880) begin
         @(negedge clock);
         rises += int'(prof && !last);
         high += int'(prof);
         seen |= coil != 4'h0;
         last = prof;
      end
      check(rises, 2 * int'(c) + 4);
      check(high > 1368 && high < 1512, 1'h1);
      check(seen, 1'h1);
      check({fuel, cf, camf}, 3'h4);
   endtask : t_profile

   // extra tooth in the gap, cut-off, resync and clear
   task automatic t_crank;
      int n;
      restart(CYL_10, 1'h0, 1'h1, 16'h18);
      wait_for(0, 12000, n);
      @(posedge clock);
      fill <= 1'h1;
      wait_for(1, 3000, n);
      check({sync, fuel, coil, etcf}, 7'h01);
      @(posedge clock);
      fill <= 1'h0;
      wait_for(0, 12000, n);
      @(posedge clock);
      fclr <= 1'h1;
      @(posedge clock);
      fclr <= 1'h0;
      @(negedge clock);
      check({cf, etcf}, 2'h0);
   endtask : t_crank

   // overspeed tooth, then a stalled wheel
   task automatic t_speed;
      int n;
      restart(CYL_4, 1'h0, 1'h0, 16'h18);
      wait_for(0, 12000, n);
      @(posedge clock);
      period <= 16'h0A;
      wait_for(1, 1000, n);
      check(fuel, 1'h0);
      @(posedge clock);
      {run, fclr} <= 2'h1;
      @(posedge clock);
      fclr <= 1'h0;
      @(negedge clock);
      check(cf, 1'h0);
      wait_for(1, 3000, n);
      check(n > 1500, 1'h1);
   endtask : t_speed

   // below enabling speed a stall must not flag
   task automatic t_slow;
      restart(CYL_4, 1'h0, 1'h0, 16'h15E);
      repeat (1750) @(posedge clock);
      run <= 1'h0;
      repeat (2500) @(posedge clock);
      @(negedge clock);
      check({cf, sync}, 2'h0);
   endtask : t_slow

   // bank one cam edge goes missing
   task automatic t_cam;
      int n;
      restart(CYL_6, 1'h0, 1'h0, 16'h18);
      wait_for(0, 12000, n);
      check(camf, 1'h0);
      repeat (1500) @(posedge clock);
      drop <= 2'h1;
      wait_for(2, 6000, n);
      check(cf, 1'h0);
   endtask : t_cam

   // five-tooth cam, bank two loses one tooth
   task automatic t_vct;
      int n;
      restart(CYL_8, 1'h1, 1'h0, 16'h18);
      wait_for(0, 12000, n);
      repeat (3000) @(posedge clock);
      @(negedge clock);
      check({vcte, cint}, 3'h4);
      @(posedge clock);
      drop <= 2'h2;
      wait_for(3, 6000, n);
      check({vcte, cint}, 3'h2);
   endtask : t_vct

   // ==========================================================
   // main sequence
   initial begin
      {num_errors, cmp_count} = '0;
      {rst_n, run, fill, cam5, variable_cam_timing, electronic_throttle_control, fclr, drop} = '0;
      period = 16'h18;
      cyl = CYL_4;
      for (int i = 0; i < 4; i++) begin
         t_profile(ccid_cyl_t'(i));
      end
      t_crank();
      t_speed();
      t_slow();
      t_cam();
      t_vct();
      end_sim();
   end
endmodule : test_ccid_crank_cam_decoder
